// file: rtl/rxff_map.vh
`ifndef RXFF_MAP_VH
`define RXFF_MAP_VH
// Storage size in bytes and address width
`define RXFF_MEM_BYTES     16384
`define RXFF_ADDR_W        14
// Frame count limits for read requests
`define RXFF_ONE_FRAMES    7'h01
`define RXFF_TEN_FRAMES    7'h0a
`define RXFF_ALL_FRAMES    7'h40
// Read request encodings
`define RXFF_REQ_ONE       2'h1
`define RXFF_REQ_TEN       2'h2
`define RXFF_REQ_ALL       2'h3
// Frame descriptor queue depth
`define RXFF_DESC_DEPTH    64
`define RXFF_DESC_AW       6
// Output stage FIFO
`define RXFF_OUT_DEPTH     8
`define RXFF_OUT_AW        3
`endif

// file: rtl/rxff_out_fifo.v
module rxff_out_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             arst_n,
    input  wire             clear,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;

    assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign empty     = (wr_ptr == rd_ptr);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always @(posedge core_clk)
    begin
        if (in_valid && !full)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else if (clear)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (in_valid && !full)
            begin
                wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
            end
            if (out_ready && !empty)
            begin
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // rxff_out_fifo

// file: rtl/rxff_top.v
`include "rxff_map.vh"
module rxff_top #(
    parameter MEM_BYTES = `RXFF_MEM_BYTES,
    parameter AW        = `RXFF_ADDR_W
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       arst_n,
    // MAC receive stream
    input  wire [7:0] rx_data,
    input  wire       rx_valid,
    input  wire       rx_last,
    input  wire       rx_good,
    // Management commands
    input  wire       flush,
    input  wire [1:0] rd_req,
    input  wire       loopback_mode,
    output wire       rd_refused,
    output reg        rd_busy,
    // Frame read stream
    output wire [7:0] out_data,
    output wire       out_last,
    output wire       out_valid,
    input  wire       out_ready,
    // Status
    output reg        frame_dropped,
    output reg  [6:0] frames_stored
);
    localparam DAW = `RXFF_DESC_AW;

    reg  [7:0]    mem [0:MEM_BYTES-1];
    reg  [AW:0]   wr_ptr;
    reg  [AW:0]   commit_ptr;
    reg  [AW:0]   rd_ptr;
    reg           in_frame;
    reg           dropping;
    reg  [AW:0]   desc_end [0:`RXFF_DESC_DEPTH-1];
    reg  [DAW:0]  desc_wr;
    reg  [DAW:0]  desc_rd;
    reg  [6:0]    frames_left;
    reg           stage_valid;
    reg  [7:0]    stage_data;
    reg           stage_last;
    wire [AW:0]   used;
    wire          mem_full;
    wire          desc_full;
    wire          desc_empty;
    wire          accept_byte;
    wire          frame_end;
    wire          req_seen;
    wire          fifo_in_ready;
    wire [AW:0]   cur_end;
    wire          rd_active;
    wire          rd_take;
    wire [8:0]    fifo_out;
    reg  [6:0]    next_limit;

    // Fill level counts uncommitted bytes too, so a partial frame reserves space
    assign used        = wr_ptr - rd_ptr;
    assign mem_full    = (used == MEM_BYTES[AW:0]);
    assign desc_full   = (desc_wr[DAW-1:0] == desc_rd[DAW-1:0]) && (desc_wr[DAW] != desc_rd[DAW]);
    assign desc_empty  = (desc_wr == desc_rd);
    assign frame_end   = rx_valid && rx_last;
    // Byte taken only while memory and descriptor queue have room and the frame is not being dropped
    assign accept_byte = rx_valid && !dropping && !mem_full && !desc_full;

    // Write side
    always @(posedge core_clk)
    begin
        if (accept_byte)
        begin
            mem[wr_ptr[AW-1:0]] <= rx_data;
        end
    end

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr        <= {(AW+1){1'b0}};
            commit_ptr    <= {(AW+1){1'b0}};
            dropping      <= 1'b0;
            in_frame      <= 1'b0;
            desc_wr       <= {(DAW+1){1'b0}};
            frame_dropped <= 1'b0;
        end
        else if (flush)
        begin
            wr_ptr        <= {(AW+1){1'b0}};
            commit_ptr    <= {(AW+1){1'b0}};
            desc_wr       <= {(DAW+1){1'b0}};
            // A frame in flight at flush time is dropped, not half stored
            dropping      <= (in_frame || rx_valid) && !frame_end;
            in_frame      <= rx_valid ? !rx_last : in_frame;
            frame_dropped <= 1'b0;
        end
        else
        begin
            frame_dropped <= 1'b0;
            if (rx_valid)
            begin
                in_frame <= !rx_last;
            end
            if (frame_end)
            begin
                dropping <= 1'b0;
                if (accept_byte && rx_good)
                begin
                    wr_ptr              <= wr_ptr + {{AW{1'b0}}, 1'b1};
                    commit_ptr          <= wr_ptr + {{AW{1'b0}}, 1'b1};
                    desc_end[desc_wr[DAW-1:0]] <= wr_ptr + {{AW{1'b0}}, 1'b1};
                    desc_wr             <= desc_wr + {{DAW{1'b0}}, 1'b1};
                end
                else
                begin
                    wr_ptr        <= commit_ptr;
                    frame_dropped <= 1'b1;
                end
            end
            else if (rx_valid && !accept_byte)
            begin
                dropping <= 1'b1;
                wr_ptr   <= commit_ptr;
            end
            else if (accept_byte)
            begin
                wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // Read request handling
    assign rd_refused = (rd_req != 2'h0) && loopback_mode;
    assign req_seen   = (rd_req != 2'h0) && !loopback_mode && !rd_busy && !flush;

    always @*
    begin
        case (rd_req)
            `RXFF_REQ_ONE: next_limit = `RXFF_ONE_FRAMES;
            `RXFF_REQ_TEN: next_limit = `RXFF_TEN_FRAMES;
            `RXFF_REQ_ALL: next_limit = `RXFF_ALL_FRAMES;
            default:       next_limit = 7'h00;
        endcase
    end

    // Reader copies committed bytes into the output FIFO, one frame at a time
    assign cur_end   = desc_end[desc_rd[DAW-1:0]];
    assign rd_active = rd_busy && !desc_empty && (!stage_valid || fifo_in_ready);
    assign rd_take   = rd_active && (rd_ptr != cur_end);

    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_busy     <= 1'b0;
            frames_left <= 7'h00;
            rd_ptr      <= {(AW+1){1'b0}};
            desc_rd     <= {(DAW+1){1'b0}};
            stage_valid <= 1'b0;
            stage_data  <= 8'h00;
            stage_last  <= 1'b0;
        end
        else if (flush)
        begin
            rd_busy     <= 1'b0;
            frames_left <= 7'h00;
            rd_ptr      <= {(AW+1){1'b0}};
            desc_rd     <= {(DAW+1){1'b0}};
            stage_valid <= 1'b0;
            stage_last  <= 1'b0;
        end
        else
        begin
            if (stage_valid && fifo_in_ready)
            begin
                stage_valid <= 1'b0;
            end
            if (req_seen)
            begin
                rd_busy     <= 1'b1;
                frames_left <= next_limit;
            end
            else if (rd_busy && (desc_empty || frames_left == 7'h00))
            begin
                // Stop at limit or when nothing stored; reissue for more
                rd_busy <= 1'b0;
            end
            else if (rd_take)
            begin
                stage_valid <= 1'b1;
                stage_data  <= mem[rd_ptr[AW-1:0]];
                stage_last  <= ((rd_ptr + {{AW{1'b0}}, 1'b1}) == cur_end);
                rd_ptr      <= rd_ptr + {{AW{1'b0}}, 1'b1};
                if ((rd_ptr + {{AW{1'b0}}, 1'b1}) == cur_end)
                begin
                    desc_rd     <= desc_rd + {{DAW{1'b0}}, 1'b1};
                    frames_left <= frames_left - 7'h01;
                end
            end
        end
    end

    // Stored frame count
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frames_stored <= 7'h00;
        end
        else if (flush)
        begin
            // Count reads zero straight after a flush, not the stale total
            frames_stored <= 7'h00;
        end
        else
        begin
            frames_stored <= desc_wr - desc_rd;
        end
    end

    rxff_out_fifo #(
        .WIDTH (9),
        .DEPTH (`RXFF_OUT_DEPTH),
        .AW    (`RXFF_OUT_AW)
    ) u_out_fifo (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .clear     (flush),
        .in_data   ({stage_last, stage_data}),
        .in_valid  (stage_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    assign out_data = fifo_out[7:0];
    assign out_last = fifo_out[8];
endmodule // rxff_top

// file: verification/rxff_top_asserts.sv
module rxff_top_asserts (
    // Clock and reset
    input wire       core_clk,
    input wire       arst_n,
    // Inputs of the block
    input wire       rx_valid,
    input wire       rx_last,
    input wire       flush,
    input wire [1:0] rd_req,
    input wire       loopback_mode,
    input wire       out_ready,
    // Outputs of the block
    input wire       rd_refused,
    input wire       rd_busy,
    input wire [7:0] out_data,
    input wire       out_last,
    input wire       out_valid,
    input wire       frame_dropped,
    input wire [6:0] frames_stored
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence rd_take;
        rd_req != 2'h0 && !loopback_mode && !rd_busy && !flush && frames_stored != 7'h00;
    endsequence
    sequence rd_lb;
        rd_req != 2'h0 && loopback_mode && !rd_busy;
    endsequence
    refuse_flag_a: assert property (rd_refused == (rd_req != 2'h0 && loopback_mode))
        else $error("refused flag wrong");
    refuse_idle_a: assert property (rd_lb |=> !rd_busy)
        else $error("refused read started");
    read_start_a: assert property (rd_take |=> rd_busy)
        else $error("read not started");
    drop_pulse_a: assert property (frame_dropped && !rx_valid |=> !frame_dropped)
        else $error("drop pulse too long");
    drop_cause_a: assert property (frame_dropped |-> $past(rx_last) && $past(rx_valid))
        else $error("drop without frame end");
    flush_clear_a: assert property (flush |=> frames_stored == 7'h00 && !out_valid)
        else $error("flush left data");
    stored_cap_a: assert property (frames_stored <= 7'h40)
        else $error("frame count too high");
    out_hold_a: assert property (out_valid && !out_ready && !flush |=> out_valid
        && $stable(out_data) && $stable(out_last)) else $error("output not held");
endmodule // rxff_top_asserts
bind rxff_top rxff_top_asserts rxff_top_asserts_inst (.*);

// file: verification/rxff_mac_model.sv
module rxff_mac_model (
    // Clock
    input  wire        core_clk,
    // Receive stream
    output logic [7:0] rx_data,
    output logic       rx_valid,
    output logic       rx_last,
    output logic       rx_good
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_good = 1'b0;
    end
    // Bytes back to back, byte i is base plus i
    task automatic send(input int len, input logic [7:0] base, input logic good = 1'b1);
        for (int i = 0; i < len; i++)
        begin
            @(posedge core_clk);
            rx_data <= base + i[7:0];
            rx_valid <= 1'b1;
            rx_last <= (i == len - 1);
            rx_good <= good;
        end
        @(posedge core_clk);
        rx_data <= ~rx_data;
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask
endmodule // rxff_mac_model

// file: verification/rxff_top_test.sv
module rxff_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk;
    logic       arst_n;
    logic       flush;
    logic [1:0] rd_req;
    logic       loopback_mode;
    logic       out_ready;
    wire  [7:0] rx_data;
    wire        rx_valid;
    wire        rx_last;
    wire        rx_good;
    wire        rd_refused;
    wire        rd_busy;
    wire  [7:0] out_data;
    wire        out_last;
    wire        out_valid;
    wire        frame_dropped;
    wire  [6:0] frames_stored;
    int         n_mismatch;
    int         tests_run;
    int         n_drop;
    int         n_frm;
    logic [7:0] q[$];
    rxff_top rxff_top_inst (.*);
    rxff_mac_model rxff_mac_model_inst (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk)
        if (frame_dropped === 1'b1)
            n_drop++;
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic req(input logic [1:0] k, input logic lb);
        @(posedge core_clk);
        rd_req <= k;
        loopback_mode <= lb;
        @(negedge core_clk);
        check("rd_refused", lb, rd_refused);
        @(posedge core_clk);
        rd_req <= 2'h0;
        loopback_mode <= 1'b0;
    endtask
    // Drain until idle for 8 cycles; bounded
    task automatic drain;
        int idle;
        q = {};
        n_frm = 0;
        idle = 0;
        @(posedge core_clk);
        out_ready <= 1'b1;
        for (int i = 0; i < 40000 && idle < 8; i++)
        begin
            @(negedge core_clk);
            if (out_valid === 1'b1)
            begin
                q.push_back(out_data);
                n_frm += out_last;
            end
            idle = (rd_busy === 1'b0 && out_valid === 1'b0) ? idle + 1 : 0;
        end
        if (idle < 8)
        begin
            n_mismatch++;
            conclude();
        end
        @(posedge core_clk);
        out_ready <= 1'b0;
    endtask
    task automatic t_basic;
        check("frames_stored", 0, frames_stored);
        rxff_mac_model_inst.send(12, 8'h10);
        rxff_mac_model_inst.send(12, 8'h20);
        rxff_mac_model_inst.send(12, 8'h30);
        req(2'h3, 1'b1);
        repeat (4) @(negedge core_clk);
        check("rd_busy", 0, rd_busy);
        check("frames_stored", 3, frames_stored);
        $display("test basic done");
    endtask
    task automatic t_read_one;
        fork
            rxff_mac_model_inst.send(200, 8'h40);
            begin
                req(2'h1, 1'b0);
                repeat (20) @(negedge core_clk);
                check("out_valid", 1, out_valid);
                drain();
            end
        join
        check("frames read", 1, n_frm);
        check("bytes read", 12, q.size());
        check("first byte", 8'h10, q[0]);
        check("last byte", 8'h1b, q[11]);
        repeat (2) @(negedge core_clk);
        check("frames_stored", 3, frames_stored);
        $display("test read one done");
    endtask
    task automatic t_fill;
        @(posedge core_clk);
        flush <= 1'b1;
        @(posedge core_clk);
        flush <= 1'b0;
        @(negedge core_clk);
        check("frames_stored", 0, frames_stored);
        n_drop = 0;
        repeat (15) rxff_mac_model_inst.send(1024, 8'h00);
        rxff_mac_model_inst.send(2000, 8'h00);
        rxff_mac_model_inst.send(1024, 8'h00);
        rxff_mac_model_inst.send(1, 8'h00);
        repeat (3) @(negedge core_clk);
        check("frames dropped", 2, n_drop);
        check("frames_stored", 16, frames_stored);
        $display("test fill done");
    endtask
    task automatic t_read_rest;
        req(2'h2, 1'b0);
        drain();
        check("frames read", 10, n_frm);
        check("bytes read", 16'h2800, q.size());
        req(2'h3, 1'b0);
        drain();
        check("frames read", 6, n_frm);
        check("frames_stored", 0, frames_stored);
        $display("test read rest done");
    endtask
    // Bad frame, descriptor limit, then read-all limit while frames arrive
    task automatic t_limit;
        n_drop = 0;
        rxff_mac_model_inst.send(4, 8'h60, 1'b0);
        repeat (65) rxff_mac_model_inst.send(1, 8'h55);
        repeat (3) @(negedge core_clk);
        check("frames dropped", 2, n_drop);
        check("frames_stored", 64, frames_stored);
        fork
            begin
                repeat (8) @(posedge core_clk);
                repeat (10) rxff_mac_model_inst.send(1, 8'h70);
            end
            begin
                req(2'h3, 1'b0);
                drain();
            end
        join
        check("frames read", 64, n_frm);
        check("bytes read", 64, q.size());
        check("last byte", 8'h55, q[63]);
        check("frames_stored", 10, frames_stored);
        $display("test limit done");
    endtask
    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        n_drop = 0;
        arst_n = 1'b0;
        flush = 1'b0;
        rd_req = 2'h0;
        loopback_mode = 1'b0;
        out_ready = 1'b0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_basic();
        t_read_one();
        t_fill();
        t_read_rest();
        t_limit();
        conclude();
    end
endmodule // rxff_top_test
